// ==== design/asp_sync.sv ====
// Purpose: Two-flop synchroniser for a group of asynchronous pins
// Assumes: Each bit is independent; no bus coherency required
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module asp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    // Data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule

// ==== design/asp_top.sv ====
// Purpose: Conversion sequencer and three-wire serial port of the converter
// Assumes: Pins and comparator are asynchronous; serial clock is slow
//          enough (well under the core clock) for edge detection
// Notes:   Config byte: upper nibble integrate, lower nibble auto-zero
`timescale 1ns/1ps
module asp_top
    import asp_pkg::*;
#(
    parameter logic [asp_pkg::TMR_W-1:0] UNIT_CYC_P =
        asp_pkg::TMR_W'(asp_pkg::UNIT_CYC)
) (
    // Clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    reset_i,
    // Serial port pins
    input  wire asp_pkg::asp_serial_in_t serial_i,
    output logic                         serial_out_o,
    output logic                         serial_out_oe_o,
    // Conversion control pins
    input  wire logic                    conv_reset_i,
    input  wire logic                    cmp_i,
    output logic                         eoc_o,
    output logic                         eoc_oe_o,
    output logic                         autozero_phase_o
);
    import asp_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] sync_w;
    logic              clk_s;
    logic              rw_s;
    logic              din_s;
    logic              crst_s;
    logic              cmp_s;

    asp_sync #(.W(SYNC_W)) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   ({serial_i.shift_clk, serial_i.read_sel,
                     serial_i.data_in, conv_reset_i, cmp_i}),
        .sync_o    (sync_w)
    );

    assign {clk_s, rw_s, din_s, crst_s, cmp_s} = sync_w;

    // ------------------------------------------------------------------
    // Duration decode
    // ------------------------------------------------------------------
    function automatic logic [TMR_W-1:0] dur_last(
        input logic [SEL_W-1:0] sel
    );
        logic [TMR_W-1:0] steps;
        steps = {{(TMR_W-SEL_W){1'b0}}, sel} + 20'h00001;
        return TMR_W'(steps * UNIT_CYC_P) - 20'h00001;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    asp_state_t          state_reg,   state_next;
    logic [TMR_W-1:0]    timer_reg,   timer_next;
    logic                pol_reg,     pol_next;
    logic [RES_W-1:0]    shift_reg,   shift_next;
    asp_cfg_t            cfg_reg,     cfg_next;
    logic [CFG_W-1:0]    cfg_sh_reg,  cfg_sh_next;
    logic [BITCNT_W-1:0] bit_reg,     bit_next;
    logic                clk_d_reg;
    logic                sout_reg,    sout_next;
    logic                soe_reg,     soe_next;
    logic                eoe_reg,     eoe_next;
    logic                load;
    logic                rise;
    logic                fall;
    logic [CFG_W-1:0]    cfg_asm;
    asp_result_t         result_w;

    assign rise    = clk_s & ~clk_d_reg;
    assign fall    = ~clk_s & clk_d_reg;
    assign cfg_asm = {cfg_sh_reg[CFG_W-2:0], din_s};
    assign result_w = '{overrange: (timer_reg >= CNT_MAX),
                        polarity:  pol_reg,
                        count:     timer_reg[CNT_W-1:0]};

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_next  = state_reg;
        timer_next  = timer_reg;
        pol_next    = pol_reg;
        shift_next  = shift_reg;
        cfg_next    = cfg_reg;
        cfg_sh_next = cfg_sh_reg;
        bit_next    = bit_reg;
        load        = 1'b0;

        // Conversion sequencer; a high reset pin parks it in auto-zero
        if (crst_s) begin
            state_next = ST_AZ;
            timer_next = '0;
        end else begin
            case (state_reg)
                ST_AZ: begin
                    // Durations are read live so a rewrite takes effect
                    if (timer_reg >= dur_last(cfg_reg.autozero_duration)) begin
                        state_next = ST_INT;
                        timer_next = '0;
                    end else begin
                        timer_next = timer_reg + 20'h00001;
                    end
                end
                ST_INT: begin
                    if (timer_reg >=
                        dur_last(cfg_reg.integrate_duration)) begin
                        state_next = ST_DEINT;
                        timer_next = '0;
                        pol_next   = cmp_s;
                    end else begin
                        timer_next = timer_reg + 20'h00001;
                    end
                end
                ST_DEINT: begin
                    // Ends on zero crossing or on count overflow
                    if (cmp_s != pol_reg || timer_reg >= CNT_MAX) begin
                        state_next = ST_AZ;
                        timer_next = '0;
                        load       = 1'b1;
                    end else begin
                        timer_next = timer_reg + 20'h00001;
                    end
                end
                default: begin
                    state_next = ST_AZ;
                    timer_next = '0;
                end
            endcase
        end

        // Serial port
        if (rw_s) begin
            bit_next = '0;
            if (fall) begin
                shift_next = {shift_reg[RES_W-2:0], 1'b0};
            end
        end else if (rise) begin
            cfg_sh_next = cfg_asm;
            bit_next    = bit_reg + 3'h1;
            if (bit_reg == LAST_BIT) begin
                cfg_next = asp_cfg_t'(cfg_asm);
                bit_next = '0;
            end
        end

        // A fresh result replaces any half-read one
        if (load) begin
            shift_next = result_w;
        end

        sout_next = shift_next[RES_W-1];
        soe_next  = rw_s;
        eoe_next  = (state_next == ST_AZ);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_reg  <= ST_AZ;
            timer_reg  <= '0;
            pol_reg    <= 1'b0;
            shift_reg  <= RES_RST;
            cfg_reg    <= asp_cfg_t'(CFG_RST);
            cfg_sh_reg <= CFG_RST;
            bit_reg    <= '0;
            clk_d_reg  <= 1'b0;
            sout_reg   <= 1'b0;
            soe_reg    <= 1'b0;
            eoe_reg    <= 1'b1;
        end else begin
            state_reg  <= state_next;
            timer_reg  <= timer_next;
            pol_reg    <= pol_next;
            shift_reg  <= shift_next;
            cfg_reg    <= cfg_next;
            cfg_sh_reg <= cfg_sh_next;
            bit_reg    <= bit_next;
            clk_d_reg  <= clk_s;
            sout_reg   <= sout_next;
            soe_reg    <= soe_next;
            eoe_reg    <= eoe_next;
        end
    end

    // Open drain eoc: its level is always low, only eoc_oe_o moves; serial out drives sout_reg
    assign serial_out_o     = sout_reg;
    assign serial_out_oe_o  = soe_reg;
    assign eoc_o            = 1'b0;
    assign eoc_oe_o         = eoe_reg;
    assign autozero_phase_o = eoe_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_deint_end;
        (state_reg == ST_DEINT) ##1 (state_reg == ST_AZ);
    endsequence

    sequence s_last_bit;
        !rw_s && rise && (bit_reg == LAST_BIT);
    endsequence

    a_oe_follows_rw: assert property (
        !rw_s |=> !serial_out_oe_o)
        else $error("serial output driven while select low");

    a_oe_on_read: assert property (
        rw_s ##1 rw_s |-> serial_out_oe_o)
        else $error("serial output not driven during read");

    a_shift_on_fall: assert property (
        rw_s && fall && !load |=>
            shift_reg == {$past(shift_reg[RES_W-2:0]), 1'b0})
        else $error("result not shifted on falling edge");

    a_cfg_byte_msb: assert property (
        s_last_bit |=> cfg_reg == $past(cfg_asm))
        else $error("config byte not assembled msb first");

    a_az_duration: assert property (
        state_reg == ST_AZ && !crst_s &&
        timer_reg == dur_last(cfg_reg.autozero_duration) |=>
            state_reg == ST_INT)
        else $error("auto-zero length not from config");

    a_int_duration: assert property (
        state_reg == ST_INT && !crst_s &&
        timer_reg == dur_last(cfg_reg.integrate_duration) |=>
            state_reg == ST_DEINT)
        else $error("integrate length not from config");

    a_eoc_in_az: assert property (
        state_reg == ST_AZ |-> eoc_oe_o)
        else $error("eoc released during auto-zero");

    a_eoc_released: assert property (
        state_reg != ST_AZ ##1 state_reg != ST_AZ |-> !eoc_oe_o)
        else $error("eoc held outside auto-zero");

    a_eoc_complete: assert property (
        s_deint_end |-> eoc_oe_o)
        else $error("eoc late after conversion end");

    a_halt_in_az: assert property (
        crst_s [*2] |-> state_reg == ST_AZ && timer_reg == '0)
        else $error("conversion not halted by reset");

    a_result_load: assert property (
        load |=> shift_reg == $past(result_w))
        else $error("result not loaded at completion");
endmodule

// ==== shared/asp_pkg.sv ====
// Purpose: Constants and types for the converter serial port control block
// Assumes: Core clock of 10 MHz; all pins asynchronous to it
// Notes:   Timing, field sizes, reset values and types follow
package asp_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    // One step of a duration field
    localparam int DUR_UNIT_NS   = 100000;
    localparam int UNIT_CYC      = DUR_UNIT_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Field layout and sizes
    // ------------------------------------------------------------------
    localparam int CFG_W      = 8;
    localparam int SEL_W      = 4;
    localparam int TMR_W      = 20;
    localparam int CNT_W      = 16;
    localparam int RES_W      = CNT_W + 2;
    localparam int BITCNT_W   = 3;
    localparam int SYNC_W     = 5;
    localparam logic [TMR_W-1:0] CNT_MAX = 20'h0FFFF;
    localparam logic [BITCNT_W-1:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
    localparam logic [RES_W-1:0] RES_RST = 18'h00000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_AZ    = 2'h0,
        ST_INT   = 2'h1,
        ST_DEINT = 2'h3
    } asp_state_t;

    typedef struct packed {
        logic shift_clk;
        logic read_sel;
        logic data_in;
    } asp_serial_in_t;

    typedef struct packed {
        logic [SEL_W-1:0] integrate_duration;
        logic [SEL_W-1:0] autozero_duration;
    } asp_cfg_t;

    typedef struct packed {
        logic             overrange;
        logic             polarity;
        logic [CNT_W-1:0] count;
    } asp_result_t;

endpackage

// ==== verification/adc_serial_port_control_tb.sv ====
// Purpose: Self-checking bench for the converter serial port control
// Assumes: Duration unit shortened to 4 core cycles
// Notes:   Drivers queue expectations, monitors pop and compare
`timescale 1ns/1ps
module adc_serial_port_control_tb;
    import asp_pkg::*;

    localparam int U = 4;
    logic             ref_clk_i = 1'b0;
    logic             reset_i = 1'b1;
    logic             conv_reset_i = 1'b1;
    logic             cmp_i = 1'b1;
    asp_serial_in_t   serial;
    logic             s_out, s_oe, eoc, eoc_oe, az_phase, rd_stb;
    logic             eoc_n_line;
    logic [RES_W-1:0] rd_word;
    logic [RES_W-1:0] exp_w;
    logic [RES_W-1:0] msk_w;
    logic [RES_W-1:0] word_q[$];
    logic [RES_W-1:0] mask_q[$];
    int               width_q[$];
    int               fail_count = 0;
    int               total_checks = 0;
    int               run_len = 0;
    logic             armed = 1'b0;
    logic [CFG_W-1:0] cfg;
    int               n;

    always #50 ref_clk_i = ~ref_clk_i;
    // Open-drain line with pull-up
    assign eoc_n_line = (eoc_oe === 1'b1) ? eoc : 1'b1;

    // Step tick of clock / 4 stays under the external timebase limit
    asp_top #(.UNIT_CYC_P(20'h00004)) u_asp_top (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .serial_i(serial),
        .serial_out_o(s_out), .serial_out_oe_o(s_oe),
        .conv_reset_i(conv_reset_i), .cmp_i(cmp_i), .eoc_o(eoc),
        .eoc_oe_o(eoc_oe), .autozero_phase_o(az_phase)
    );
    asp_host_model u_asp_host_model (
        .ref_clk_i(ref_clk_i), .serial_o(serial), .serial_out_i(s_out),
        .serial_out_oe_i(s_oe), .rd_word_o(rd_word), .rd_stb_o(rd_stb)
    );

    // ------------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------------
    task automatic mismatch(input logic [31:0] e, input logic [31:0] a);
        fail_count++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
    endtask
    task automatic compare_word(input logic [RES_W-1:0] e,
                                input logic [RES_W-1:0] m,
                                input logic [RES_W-1:0] a);
        total_checks++;
        if ((a & m) !== (e & m)) mismatch(32'(e), 32'(a));
    endtask
    task automatic compare_count(input int e, input int a);
        total_checks++;
        if (e != a) mismatch(32'(e), 32'(a));
    endtask
    task automatic compare_level(input logic e, input logic a);
        total_checks++;
        if (a !== e) mismatch(32'(e), 32'(a));
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Bounded wait for the next result load
    task automatic wait_load(input int lim);
        int k;
        k = 0;
        while (eoc_n_line !== 1'b1 && k < lim) begin
            @(negedge ref_clk_i);
            k++;
        end
        while (eoc_n_line !== 1'b0 && k < lim) begin
            @(negedge ref_clk_i);
            k++;
        end
        if (k >= lim) begin
            mismatch(32'(lim), 32'(k));
            complete_run();
        end
    endtask

    // ------------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (rd_stb === 1'b1) begin
            if (word_q.size() == 0) mismatch(32'h0, 32'(rd_word));
            else begin
                exp_w = word_q.pop_front();
                msk_w = mask_q.pop_front();
                compare_word(exp_w, msk_w, rd_word);
            end
        end
    end
    // Only pulses that begin after an expectation is queued are measured
    always @(posedge ref_clk_i) begin
        if (reset_i || eoc_n_line !== 1'b0) begin
            if (armed) compare_count(width_q.pop_front(), run_len);
            armed = 1'b0;
            run_len = 0;
        end else begin
            if (run_len == 0) armed = (width_q.size() > 0);
            run_len++;
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        n = $urandom(44279);
        repeat (16) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        reset_i = 1'b0;
        // Config write, then an overranged conversion
        cfg = 8'($urandom());
        u_asp_host_model.write_cfg(cfg);
        compare_level(1'b0, s_oe);
        width_q.push_back((int'(cfg[3:0]) + 1) * U);
        conv_reset_i = 1'b0;
        wait_load(70000);
        word_q.push_back({1'b1, 1'b1, 16'hFFFF});
        mask_q.push_back({RES_W{1'b1}});
        u_asp_host_model.read_word();
        $display("test overrange done");
        // Rewrite mid-conversion, comparator trips in de-integrate
        cfg = 8'($urandom());
        u_asp_host_model.write_cfg(cfg);
        width_q.push_back((int'(cfg[3:0]) + 1) * U);
        repeat (150) @(negedge ref_clk_i);
        cmp_i = 1'b0;
        wait_load(1000);
        word_q.push_back({1'b0, 1'b1, 16'h0000});
        mask_q.push_back(18'h30000);
        u_asp_host_model.read_word();
        $display("test rewrite done");
        // Opposite polarity ends the next conversion; halt only in auto-zero
        cmp_i = 1'b1;
        wait_load(1000);
        conv_reset_i = 1'b1;
        word_q.push_back({1'b0, 1'b0, 16'h0000});
        mask_q.push_back(18'h30000);
        u_asp_host_model.read_word();
        repeat (5) @(negedge ref_clk_i);
        n = 0;
        repeat (40) begin
            @(negedge ref_clk_i);
            if (eoc_n_line === 1'b0 && az_phase === 1'b1) n++;
        end
        compare_count(40, n);
        $display("test halt done");
        compare_count(0, word_q.size() + width_q.size());
        complete_run();
    end
endmodule

// ==== verification/asp_host_model.sv ====
// Purpose: Host model driving the three-wire serial port
// Assumes: Link clock period 800 ns, idle low between frames
// Notes:   Undriven data out reads as the inverse of its last level
`timescale 1ns/1ps
module asp_host_model (
    // Clock
    input  wire logic                 ref_clk_i,
    // Serial port
    output asp_pkg::asp_serial_in_t   serial_o,
    input  wire logic                 serial_out_i,
    input  wire logic                 serial_out_oe_i,
    // Read results
    output logic [asp_pkg::RES_W-1:0] rd_word_o,
    output logic                      rd_stb_o
);
    import asp_pkg::*;

    logic line_last;
    logic line;

    initial begin
        serial_o = '0;
        rd_word_o = '0;
        rd_stb_o = 1'b0;
        line_last = 1'b0;
    end

    // A released pin must not pass for the last bit
    assign line = serial_out_oe_i ? serial_out_i : ~line_last;
    always @(posedge ref_clk_i) begin
        if (serial_out_oe_i === 1'b1) line_last <= serial_out_i;
    end

    task automatic half();
        repeat (4) @(negedge ref_clk_i);
    endtask

    task automatic write_cfg(input logic [CFG_W-1:0] b);
        serial_o.read_sel = 1'b0;
        for (int i = CFG_W - 1; i >= 0; i--) begin
            serial_o.data_in = b[i];
            half();
            serial_o.shift_clk = 1'b1;
            half();
            serial_o.shift_clk = 1'b0;
        end
        serial_o.data_in = ~b[0];
    endtask

    task automatic read_word();
        logic [RES_W-1:0] w;
        serial_o.read_sel = 1'b1;
        repeat (3) half();
        for (int i = RES_W - 1; i >= 0; i--) begin
            w[i] = line;
            serial_o.shift_clk = 1'b1;
            half();
            serial_o.shift_clk = 1'b0;
            half();
        end
        serial_o.read_sel = 1'b0;
        rd_word_o = w;
        rd_stb_o = 1'b1;
        @(negedge ref_clk_i);
        rd_stb_o = 1'b0;
    endtask
endmodule
